//--- shared/mdbp_params.svh
// Register offsets, field positions and encodings of the modem data buffer path.
`ifndef MDBP_PARAMS_SVH
`define MDBP_PARAMS_SVH

// ---------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------
`define MDBP_A_CMD_CTRL 8'h48
`define MDBP_A_CMD_DATA 8'h49
`define MDBP_A_CMD_WORD 8'h4A
`define MDBP_A_CMD_LVL 8'h4B
`define MDBP_A_RX_CTRL 8'h4C
`define MDBP_A_RX_DATA 8'h4D
`define MDBP_A_RX_WORD 8'h4E
`define MDBP_A_RX_LVL 8'h4F
`define MDBP_A_FIFO_CTL 8'h50
`define MDBP_A_MODE 8'h6B
`define MDBP_A_BUF_LVL 8'h70

// ---------------------------------------------------------------------
// Field positions and encodings
// ---------------------------------------------------------------------
`define MDBP_FC_FLUSH_CMD 15
`define MDBP_FC_FLUSH_RX 14
`define MDBP_FC_CMD_THR_HI 13
`define MDBP_FC_CMD_THR_LO 7
`define MDBP_FC_RX_THR_HI 6
`define MDBP_FC_RX_THR_LO 0
`define MDBP_MODE_FMT 0
`define MDBP_CTL_BITWISE 7
`define MDBP_CTL_RAW_BYTE 8'h00
`define MDBP_CTL_PART 8'h80
`define MDBP_MAX_BPS 3'h6

`endif

//--- shared/mdbp_pkg.sv
// Types shared by the modem data buffer path.
package mdbp_pkg;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] data;
   } mdbp_ent_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } mdbp_reg_req_t;

endpackage : mdbp_pkg

//--- verilog/mdbp_buffer_path.sv
// Command and receive FIFOs with their internal buffers, raw and formatted data paths.
`timescale 1ns/100ps
`default_nettype none
`include "mdbp_params.svh"

module mdbp_buffer_path #(
   parameter int DEPTH = 128
) (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire mdbp_pkg::mdbp_reg_req_t i_reg,
   output logic [15:0] o_reg_rdata,
   input wire logic i_frame_start,
   input wire logic i_cs_fallback,
   input wire logic [2:0] i_bits_per_sym,
   input wire logic i_tx_en,
   output logic [5:0] o_tx_sym,
   output logic o_tx_sym_valid,
   input wire logic i_tx_sym_ready,
   output logic o_blk_done,
   output mdbp_pkg::mdbp_ent_t o_tx_fmt,
   output logic o_tx_fmt_valid,
   input wire logic [5:0] i_rx_sym,
   input wire logic i_rx_sym_valid,
   output logic o_rx_sym_ready,
   input wire logic i_rx_end,
   input wire logic [7:0] i_rx_blk_type,
   output logic o_cmd_lvl,
   output logic o_rx_lvl
);

   // ------------------------------------------------------------------
   // Storage and state
   // ------------------------------------------------------------------
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   localparam int CF = 0;
   localparam int CB = 1;
   localparam int RB = 2;
   localparam int RF = 3;

   typedef struct packed {
      mdbp_pkg::mdbp_ent_t [DEPTH-1:0] mem;
      logic [AW-1:0] rd;
      logic [AW-1:0] wr;
      logic [AW:0] cnt;
   } mdbp_ring_t;

   typedef struct packed {
      mdbp_ring_t [3:0] ring;
      logic [7:0] cmd_ctrl;
      logic fmt_sel;
      logic act_fmt;
      logic [6:0] cmd_thr;
      logic [6:0] rx_thr;
      logic [15:0] rdata;
      logic [7:0] tx_sr;
      logic [3:0] tx_n;
      logic [5:0] sym_acc;
      logic [2:0] sym_cnt;
      logic [5:0] sym_out;
      logic sym_vld;
      logic [6:0] blk_cnt;
      logic blk_done;
      logic fmt_vld;
      mdbp_pkg::mdbp_ent_t fmt_ent;
      logic [5:0] rx_sr;
      logic [2:0] rx_n;
      logic [7:0] acc;
      logic [3:0] acc_n;
      logic end_pend;
      logic cmd_lvl;
      logic rx_lvl;
   } mdbp_state_t;

   mdbp_state_t s_q;
   mdbp_state_t s_d;

   // ------------------------------------------------------------------
   // Ring helpers
   // ------------------------------------------------------------------
   function automatic mdbp_ring_t ring_push(mdbp_ring_t r, mdbp_pkg::mdbp_ent_t e);
      r.mem[r.wr] = e;
      r.wr = r.wr + 1'b1;
      r.cnt = r.cnt + 1'b1;
      return r;
   endfunction : ring_push

   function automatic mdbp_ring_t ring_pop(mdbp_ring_t r);
      r.rd = r.rd + 1'b1;
      r.cnt = r.cnt - 1'b1;
      return r;
   endfunction : ring_pop

   function automatic mdbp_ring_t ring_clear(mdbp_ring_t r);
      r.rd = '0;
      r.wr = '0;
      r.cnt = '0;
      return r;
   endfunction : ring_clear

   // A zero or oversized setting is clamped so the symbol counter always wraps.
   function automatic logic [2:0] sym_bits(logic [2:0] b);
      if (b == 3'h0) begin
         return 3'h1;
      end
      if (b > `MDBP_MAX_BPS) begin
         return `MDBP_MAX_BPS;
      end
      return b;
   endfunction : sym_bits

   function automatic logic [7:0] lvl8(logic [AW:0] c);
      return 8'(c);
   endfunction : lvl8

   // Levels compare at eight bits, so a small DEPTH never cuts a threshold short.
   function automatic logic lvl_le(logic [AW:0] c, logic [6:0] t);
      return lvl8(c) <= {1'b0, t};
   endfunction : lvl_le

   function automatic logic lvl_ge(logic [AW:0] c, logic [6:0] t);
      return lvl8(c) >= {1'b0, t};
   endfunction : lvl_ge

   logic [2:0] bps;
   assign bps = sym_bits(i_bits_per_sym);

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      mdbp_pkg::mdbp_ent_t e;
      logic flush_cmd;
      logic flush_rx;
      e = '0;
      flush_cmd = 1'b0;
      flush_rx = 1'b0;
      s_d = s_q;
      s_d.blk_done = 1'b0;
      s_d.fmt_vld = 1'b0;

      // Host register reads; only the data-byte and word reads pop.
      if (i_reg.rd) begin
         e = s_q.ring[RF].mem[s_q.ring[RF].rd];
         unique case (i_reg.addr)
            `MDBP_A_RX_CTRL: s_d.rdata = {8'h00, e.ctrl};
            `MDBP_A_RX_DATA: s_d.rdata = {8'h00, e.data};
            `MDBP_A_RX_WORD: s_d.rdata = e;
            `MDBP_A_RX_LVL: s_d.rdata = {8'h00, lvl8(s_q.ring[RF].cnt)};
            `MDBP_A_CMD_LVL: s_d.rdata = {8'h00, lvl8(s_q.ring[CF].cnt)};
            `MDBP_A_BUF_LVL: s_d.rdata = {lvl8(s_q.ring[CB].cnt), lvl8(s_q.ring[RB].cnt)};
            default: s_d.rdata = 16'h0000;
         endcase
         // An empty receive FIFO answers data reads with zero and is never popped.
         if (s_q.ring[RF].cnt == '0) begin
            if (i_reg.addr != `MDBP_A_RX_LVL && i_reg.addr != `MDBP_A_CMD_LVL
                && i_reg.addr != `MDBP_A_BUF_LVL) begin
               s_d.rdata = 16'h0000;
            end
         end else if (i_reg.addr == `MDBP_A_RX_DATA || i_reg.addr == `MDBP_A_RX_WORD) begin
            s_d.ring[RF] = ring_pop(s_d.ring[RF]);
         end
      end

      // Host register writes; a write to a full command FIFO is dropped.
      if (i_reg.wr) begin
         unique case (i_reg.addr)
            `MDBP_A_CMD_CTRL: s_d.cmd_ctrl = i_reg.wdata[7:0];
            `MDBP_A_CMD_DATA: begin
               if (s_d.ring[CF].cnt != FULL) begin
                  s_d.ring[CF] = ring_push(s_d.ring[CF], {s_q.cmd_ctrl, i_reg.wdata[7:0]});
               end
            end
            `MDBP_A_CMD_WORD: begin
               s_d.cmd_ctrl = i_reg.wdata[15:8];
               if (s_d.ring[CF].cnt != FULL) begin
                  s_d.ring[CF] = ring_push(s_d.ring[CF], i_reg.wdata);
               end
            end
            `MDBP_A_FIFO_CTL: begin
               flush_cmd = i_reg.wdata[`MDBP_FC_FLUSH_CMD];
               flush_rx = i_reg.wdata[`MDBP_FC_FLUSH_RX];
               s_d.cmd_thr = i_reg.wdata[`MDBP_FC_CMD_THR_HI:`MDBP_FC_CMD_THR_LO];
               s_d.rx_thr = i_reg.wdata[`MDBP_FC_RX_THR_HI:`MDBP_FC_RX_THR_LO];
            end
            `MDBP_A_MODE: s_d.fmt_sel = i_reg.wdata[`MDBP_MODE_FMT];
            default: s_d.cmd_thr = s_d.cmd_thr;
         endcase
      end

      // The selected mode is frozen for a whole frame.
      if (i_frame_start) begin
         s_d.act_fmt = s_q.fmt_sel;
      end

      // One entry per cycle moves between each FIFO and its buffer, whatever the mode.
      if (s_d.ring[CF].cnt != '0 && s_d.ring[CB].cnt != FULL) begin
         e = s_d.ring[CF].mem[s_d.ring[CF].rd];
         s_d.ring[CF] = ring_pop(s_d.ring[CF]);
         s_d.ring[CB] = ring_push(s_d.ring[CB], e);
      end
      if (s_d.ring[RB].cnt != '0 && s_d.ring[RF].cnt != FULL) begin
         e = s_d.ring[RB].mem[s_d.ring[RB].rd];
         s_d.ring[RB] = ring_pop(s_d.ring[RB]);
         s_d.ring[RF] = ring_push(s_d.ring[RF], e);
      end

      // --------------------------------------------------------------
      // Transmit side
      // --------------------------------------------------------------
      if (s_q.sym_vld && i_tx_sym_ready) begin
         s_d.sym_vld = 1'b0;
      end
      if (s_q.tx_n == 4'h0) begin
         if (i_tx_en && s_d.ring[CB].cnt != '0) begin
            e = s_d.ring[CB].mem[s_d.ring[CB].rd];
            s_d.ring[CB] = ring_pop(s_d.ring[CB]);
            if (s_q.act_fmt) begin
               // The encoder takes the control byte as the block type.
               s_d.fmt_vld = 1'b1;
               s_d.fmt_ent = e;
            end else begin
               s_d.tx_sr = e.data;
               if (e.ctrl[`MDBP_CTL_BITWISE]) begin
                  s_d.tx_n = (e.ctrl[2:0] == 3'h0) ? 4'h8 : {1'b0, e.ctrl[2:0]};
               end else begin
                  s_d.tx_n = 4'h8;
                  // A zero block size means a plain byte stream with no block events.
                  if (e.ctrl[6:0] != 7'h00) begin
                     if (s_q.blk_cnt + 7'h01 >= e.ctrl[6:0]) begin
                        s_d.blk_cnt = 7'h00;
                        s_d.blk_done = 1'b1;
                     end else begin
                        s_d.blk_cnt = s_q.blk_cnt + 7'h01;
                     end
                  end
               end
            end
         end
      end else if (!s_d.sym_vld) begin
         // Shift the top bit out first; short counts started in the upper bits.
         s_d.sym_acc = {s_q.sym_acc[4:0], s_q.tx_sr[7]};
         s_d.tx_sr = {s_q.tx_sr[6:0], 1'b0};
         s_d.tx_n = s_q.tx_n - 4'h1;
         if (s_q.sym_cnt + 3'h1 == bps) begin
            s_d.sym_out = s_d.sym_acc;
            s_d.sym_vld = 1'b1;
            s_d.sym_cnt = 3'h0;
            s_d.sym_acc = 6'h00;
         end else begin
            s_d.sym_cnt = s_q.sym_cnt + 3'h1;
         end
      end

      // --------------------------------------------------------------
      // Receive side
      // --------------------------------------------------------------
      if (s_q.acc_n == 4'h8) begin
         if (s_d.ring[RB].cnt != FULL) begin
            s_d.ring[RB] = ring_push(s_d.ring[RB],
               {s_q.act_fmt ? i_rx_blk_type : `MDBP_CTL_RAW_BYTE, s_q.acc});
            s_d.acc_n = 4'h0;
         end
      end else if (s_q.rx_n != 3'h0) begin
         s_d.acc = {s_q.acc[6:0], s_q.rx_sr[5]};
         s_d.rx_sr = {s_q.rx_sr[4:0], 1'b0};
         s_d.rx_n = s_q.rx_n - 3'h1;
         s_d.acc_n = s_q.acc_n + 4'h1;
      end else if (i_rx_sym_valid) begin
         // Symbols arrive right-aligned; left-align them for MSB-first shifting.
         s_d.rx_sr = i_rx_sym << (3'h6 - bps);
         s_d.rx_n = bps;
      end else if (s_q.end_pend) begin
         s_d.end_pend = 1'b0;
         if (s_q.acc_n != 4'h0 && s_d.ring[RB].cnt != FULL) begin
            s_d.ring[RB] = ring_push(s_d.ring[RB], {`MDBP_CTL_PART | {5'h00, s_q.acc_n[2:0]},
               8'(s_q.acc << (4'h8 - s_q.acc_n))});
            s_d.acc_n = 4'h0;
            s_d.acc = 8'h00;
         end
      end

      // A burst end that arrives while the previous one is consumed must not be lost.
      if (i_rx_end) begin
         s_d.end_pend = 1'b1;
      end

      // --------------------------------------------------------------
      // Flushes
      // --------------------------------------------------------------
      // Apart from reset, only the host flush command and the carrier-sense fallback clear storage.
      if (flush_cmd || i_cs_fallback) begin
         s_d.ring[CF] = ring_clear(s_d.ring[CF]);
         s_d.ring[CB] = ring_clear(s_d.ring[CB]);
         s_d.blk_cnt = 7'h00;
      end
      if (flush_rx) begin
         s_d.ring[RF] = ring_clear(s_d.ring[RF]);
         s_d.ring[RB] = ring_clear(s_d.ring[RB]);
      end
      // A buffer-level read is retaken after a host flush (flush_cmd or flush_rx), so a host-flushed buffer reads zero.
      if (i_reg.rd && i_reg.addr == `MDBP_A_BUF_LVL && (flush_cmd || flush_rx)) begin
         s_d.rdata = {lvl8(s_d.ring[CB].cnt), lvl8(s_d.ring[RB].cnt)};
      end

      // --------------------------------------------------------------
      // Level flags
      // --------------------------------------------------------------
      // Room in the command FIFO, data waiting in the receive FIFO.
      s_d.cmd_lvl = lvl_le(s_d.ring[CF].cnt, s_d.cmd_thr);
      s_d.rx_lvl = (s_d.rx_thr != 7'h00) && lvl_ge(s_d.ring[RF].cnt, s_d.rx_thr);
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign o_reg_rdata = s_q.rdata;
   assign o_tx_sym = s_q.sym_out;
   assign o_tx_sym_valid = s_q.sym_vld;
   assign o_blk_done = s_q.blk_done;
   assign o_tx_fmt = s_q.fmt_ent;
   assign o_tx_fmt_valid = s_q.fmt_vld;
   // Ready comes straight from state, so a symbol is taken on the edge after the shifter empties.
   assign o_rx_sym_ready = (s_q.rx_n == 3'h0) && (s_q.acc_n != 4'h8);
   assign o_cmd_lvl = s_q.cmd_lvl;
   assign o_rx_lvl = s_q.rx_lvl;

endmodule : mdbp_buffer_path
`default_nettype wire

//--- test/mdbp_buffer_path_asserts.sv
// Concurrent checks on the ports of the modem data buffer path.
`timescale 1ns/100ps
`default_nettype none
module mdbp_chk (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire mdbp_pkg::mdbp_reg_req_t i_reg,
   input wire logic [15:0] o_reg_rdata,
   input wire logic i_cs_fallback,
   input wire logic [5:0] o_tx_sym,
   input wire logic o_tx_sym_valid,
   input wire logic i_tx_sym_ready,
   input wire logic o_blk_done,
   input wire logic i_rx_sym_valid,
   input wire logic o_rx_sym_ready,
   input wire logic i_rx_end
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   // ---------
   // Flush tracking
   // ---------
   // A side counts as clean only while nothing can have refilled it since its last flush.
   logic cmd_clean_q;
   logic rx_clean_q;
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cmd_clean_q <= 1'b1;
         rx_clean_q <= 1'b1;
      end else begin
         if (i_reg.wr && (i_reg.addr == 8'h49 || i_reg.addr == 8'h4A)) cmd_clean_q <= 1'b0;
         else if (i_cs_fallback || (i_reg.wr && i_reg.addr == 8'h50 && i_reg.wdata[15]))
            cmd_clean_q <= 1'b1;
         if ((i_rx_sym_valid && o_rx_sym_ready) || i_rx_end) rx_clean_q <= 1'b0;
         else if (i_reg.wr && i_reg.addr == 8'h50 && i_reg.wdata[14] && o_rx_sym_ready)
            rx_clean_q <= 1'b1;
      end
   end
   // ---------
   // Properties
   // ---------
   sequence s_rd(logic [7:0] a);
      i_reg.rd && !i_reg.wr && i_reg.addr == a;
   endsequence
   sequence s_gap;
      (!i_reg.wr && !i_reg.rd) [*2];
   endsequence
   property p_cmd_lvl;
      cmd_clean_q ##0 s_rd(8'h4B) |=> o_reg_rdata == 16'h0000;
   endproperty
   property p_cmd_buf;
      cmd_clean_q ##0 s_rd(8'h70) |=> o_reg_rdata[15:8] == 8'h00;
   endproperty
   property p_rx_lvl;
      rx_clean_q ##0 s_rd(8'h4F) |=> o_reg_rdata == 16'h0000;
   endproperty
   property p_rx_buf;
      rx_clean_q ##0 s_rd(8'h70) |=> o_reg_rdata[7:0] == 8'h00;
   endproperty
   property p_ctl_keep;
      s_rd(8'h4C) ##1 s_gap ##1 (s_rd(8'h4C) ##0 o_reg_rdata != 16'h0000)
         |=> o_reg_rdata == $past(o_reg_rdata);
   endproperty
   property p_sym_hold;
      o_tx_sym_valid && !i_tx_sym_ready |=> o_tx_sym_valid && $stable(o_tx_sym);
   endproperty
   property p_blk_gap;
      o_blk_done |=> !o_blk_done [*7];
   endproperty
   property p_rx_busy;
      i_rx_sym_valid && o_rx_sym_ready |=> !o_rx_sym_ready;
   endproperty
   a_cmd_lvl: assert property (p_cmd_lvl)
      else $error("command level not zero after flush");
   a_cmd_buf: assert property (p_cmd_buf)
      else $error("command buffer level not zero after flush");
   a_rx_lvl: assert property (p_rx_lvl)
      else $error("receive level not zero after flush");
   a_rx_buf: assert property (p_rx_buf)
      else $error("receive buffer level not zero after flush");
   a_ctl_keep: assert property (p_ctl_keep)
      else $error("control read changed the receive head");
   a_sym_hold: assert property (p_sym_hold)
      else $error("stalled symbol changed");
   a_blk_gap: assert property (p_blk_gap)
      else $error("block done pulses too close");
   a_rx_busy: assert property (p_rx_busy)
      else $error("receive ready while shifting");
endmodule : mdbp_chk
bind mdbp_buffer_path mdbp_chk chk_u (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_reg(i_reg),
   .o_reg_rdata(o_reg_rdata), .i_cs_fallback(i_cs_fallback), .o_tx_sym(o_tx_sym),
   .o_tx_sym_valid(o_tx_sym_valid), .i_tx_sym_ready(i_tx_sym_ready), .o_blk_done(o_blk_done),
   .i_rx_sym_valid(i_rx_sym_valid), .o_rx_sym_ready(o_rx_sym_ready), .i_rx_end(i_rx_end));
`default_nettype wire

//--- test/mdbp_host_model.sv
// Host model that reaches the registers through the parallel register request port.
`timescale 1ns/100ps
`default_nettype none
module mdbp_host_model (
   input wire logic i_mclk,
   input wire logic [15:0] i_rdata,
   output var mdbp_pkg::mdbp_reg_req_t o_reg
);
   initial o_reg = '{1'b0, 1'b0, 8'h00, 16'h0000};
   // A released port shows inverted address and data, so a stale value never looks valid.
   task automatic req(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge i_mclk);
      #1 o_reg = '{w, !w, a, d};
      @(posedge i_mclk);
      #1 o_reg = '{1'b0, 1'b0, ~a, ~d};
   endtask : req
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      req(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      req(1'b0, a, 16'h0000);
      @(posedge i_mclk);
      d = i_rdata;
      #1;
   endtask : rd
endmodule : mdbp_host_model
`default_nettype wire

//--- test/tb.sv
// Self-checking bench of the modem data buffer path.
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic frame = 1'b0;
   logic fallback = 1'b0;
   logic [2:0] bps = 3'h1;
   logic tx_en = 1'b0;
   logic tx_rdy = 1'b0;
   logic [5:0] rx_sym = 6'h00;
   logic rx_vld = 1'b0;
   logic rx_end = 1'b0;
   logic [7:0] blk_type = 8'h00;
   logic [2:0] bps_tbl [4] = '{3'h1, 3'h2, 3'h4, 3'h5};
   mdbp_pkg::mdbp_reg_req_t req;
   mdbp_pkg::mdbp_ent_t tx_fmt;
   logic [15:0] rdata, d, d2, lv;
   logic [5:0] tx_sym, e;
   logic tx_vld, blk_done, fmt_vld, rx_rdy, cmd_lvl, rx_lvl;
   int mismatches = 0;
   int checked = 0;
   int cycles = 0;
   int blks = 0;
   int n;
   logic [15:0] fmtq[$], rxq[$];
   logic txq[$];
   always #5 clk = ~clk;
   mdbp_buffer_path #(.DEPTH(8)) dut_u (.i_mclk(clk), .i_rst_b(rst_b), .i_reg(req),
      .o_reg_rdata(rdata), .i_frame_start(frame), .i_cs_fallback(fallback),
      .i_bits_per_sym(bps), .i_tx_en(tx_en), .o_tx_sym(tx_sym), .o_tx_sym_valid(tx_vld),
      .i_tx_sym_ready(tx_rdy), .o_blk_done(blk_done), .o_tx_fmt(tx_fmt),
      .o_tx_fmt_valid(fmt_vld), .i_rx_sym(rx_sym), .i_rx_sym_valid(rx_vld),
      .o_rx_sym_ready(rx_rdy), .i_rx_end(rx_end), .i_rx_blk_type(blk_type),
      .o_cmd_lvl(cmd_lvl), .o_rx_lvl(rx_lvl));
   mdbp_host_model host_u (.i_mclk(clk), .i_rdata(rdata), .o_reg(req));
   // ---------
   // Checking helpers
   // ---------
   task automatic chk(input logic [15:0] x, input logic [15:0] y);
      checked++;
      if (y !== x) begin
         mismatches++;
         $display("[FAIL] %0t exp %h got %h", $time, x, y);
      end
   endtask : chk
   task print_verdict;
      if (mismatches == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   task automatic pulse(ref logic s);
      @(posedge clk);
      #1 s = 1'b1;
      @(posedge clk);
      #1 s = 1'b0;
   endtask : pulse
   task automatic rxs(input logic [5:0] v);
      @(posedge clk);
      #1 rx_sym = v;
      rx_vld = 1'b1;
      while (!rx_rdy) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      #1 rx_vld = 1'b0;
      rx_sym = ~v;
   endtask : rxs
   always @(posedge clk) begin
      cycles++;
      if (rst_b && tx_vld && tx_rdy) begin
         e = 6'h00;
         for (int i = 0; i < bps; i++) e = {e[4:0], txq.pop_front()};
         chk({10'h000, e}, {10'h000, tx_sym});
      end
      if (fmt_vld) chk(fmtq.pop_front(), tx_fmt);
      if (blk_done) blks++;
      if (cycles == 30000) begin
         mismatches++;
         print_verdict();
      end
   end
   always @(posedge clk) #1 tx_rdy = 1'($urandom_range(0, 1));
   // ---------
   // Scenarios
   // ---------
   initial begin
      n = $urandom(32'hd92a);
      repeat (16) @(posedge clk);
      #1 rst_b = 1'b1;
      host_u.rd(8'h70, d);
      chk(16'h0000, d);
      for (int k = 0; k < 2; k++) begin
         n = $urandom_range(3, 6) + 8 * k;
         for (int i = 0; i < n; i++) host_u.wr(8'h4A, 16'($urandom));
         repeat (20) @(posedge clk);
         host_u.rd(8'h4B, d);
         host_u.rd(8'h70, d2);
         chk(16'(n), d + {8'h00, d2[15:8]});
         chk(16'((n > 8) ? n - 8 : 0), d);
         chk({15'h0000, n <= 8}, {15'h0000, cmd_lvl});
         if (k == 0) pulse(fallback);
         else host_u.wr(8'h50, 16'h8000);
         host_u.rd(8'h4B, d);
         chk(16'h0000, d);
         host_u.rd(8'h70, d);
         chk(16'h0000, {8'h00, d[15:8]});
      end
      for (int r = 0; r < 2; r++) begin
         bps = bps_tbl[$urandom_range(0, 3)];
         blks = 0;
         host_u.wr(8'h48, r ? 16'h0000 : 16'h0002);
         for (int i = 0; i < 3; i++) begin
            d = {(i == 2) ? 8'h84 : 8'h00, 8'($urandom)};
            if (i < 2) host_u.wr(8'h49, d);
            else host_u.wr(8'h4A, d);
            for (int b = 7; b >= ((i == 2) ? 4 : 0); b--) txq.push_back(d[b]);
         end
         tx_en = 1'b1;
         for (int t = 0; t < 400 && txq.size() > 0; t++) @(posedge clk);
         repeat (4) @(posedge clk);
         #1 tx_en = 1'b0;
         chk(16'h0000, 16'(txq.size()));
         chk(r ? 16'h0000 : 16'h0001, 16'(blks));
      end
      host_u.wr(8'h6B, 16'h0001);
      pulse(frame);
      tx_en = 1'b1;
      for (int i = 0; i < 3; i++) begin
         d = 16'($urandom);
         fmtq.push_back(d);
         host_u.wr(8'h4A, d);
      end
      for (int t = 0; t < 200 && fmtq.size() > 0; t++) @(posedge clk);
      #1 tx_en = 1'b0;
      chk(16'h0000, 16'(fmtq.size()));
      bps = 3'h4;
      host_u.wr(8'h50, 16'h0002);
      for (int m = 0; m < 2; m++) begin
         host_u.wr(8'h6B, 16'(m));
         blk_type = 8'($urandom_range(1, 255));
         pulse(frame);
         for (int i = 0; i < 4; i++) begin
            d = {8'h00, 8'($urandom)};
            rxq.push_back(i == 3 ? {8'h84, d[7:4], 4'h0} : {m ? blk_type : 8'h00, d[7:0]});
            rxs({2'b00, d[7:4]});
            if (i < 3) rxs({2'b00, d[3:0]});
         end
         pulse(rx_end);
         lv = 16'h0000;
         for (int t = 0; t < 50 && lv != 16'h0004; t++) host_u.rd(8'h4F, lv);
         chk(16'h0001, {15'h0000, rx_lvl});
         for (int j = 0; j < 2; j++) begin
            host_u.rd(8'h4C, d);
            chk({8'h00, rxq[0][15:8]}, {8'h00, d[7:0]});
         end
         for (int j = 0; j < 4; j++) begin
            host_u.rd(j[0] ? 8'h4D : 8'h4E, d);
            chk(j[0] ? {8'h00, rxq[0][7:0]} : rxq[0], j[0] ? {8'h00, d[7:0]} : d);
            void'(rxq.pop_front());
         end
         host_u.rd(8'h4F, d);
         chk(16'h0000, d);
      end
      rxs(6'h0A);
      rxs(6'h05);
      repeat (20) @(posedge clk);
      host_u.rd(8'h4F, d);
      host_u.rd(8'h70, d2);
      chk(16'h0001, d + {8'h00, d2[7:0]});
      host_u.wr(8'h50, 16'h4000);
      host_u.rd(8'h70, d);
      chk(16'h0000, {8'h00, d[7:0]});
      host_u.rd(8'h4F, d);
      chk(16'h0000, d);
      print_verdict();
   end
endmodule : tb
`default_nettype wire
